// File: logic/flash_seq_pkg.sv
package flash_seq_pkg;
   // Register byte addresses
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_AREA = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_ENTRY = 8'h0C;
   localparam logic [7:0] OFS_DATA_CTRL = 8'h10;
   localparam logic [7:0] OFS_SAH = 8'h14;
   localparam logic [7:0] OFS_SAL = 8'h18;
   localparam logic [7:0] OFS_EAH = 8'h1C;
   localparam logic [7:0] OFS_EAL = 8'h20;
   localparam logic [7:0] OFS_WBH = 8'h24;
   localparam logic [7:0] OFS_WBL = 8'h28;
   localparam logic [7:0] OFS_RBH = 8'h2C;
   localparam logic [7:0] OFS_RBL = 8'h30;
   localparam logic [7:0] OFS_STAT1 = 8'h34;
   localparam logic [7:0] OFS_EAM = 8'h38;
   localparam logic [7:0] OFS_WSM = 8'h3C;
   localparam logic [7:0] OFS_WEM = 8'h40;
   localparam logic [7:0] OFS_SCM = 8'h44;
   localparam logic [7:0] OFS_PROT = 8'h48;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h4C;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h50;
   localparam logic [7:0] OFS_IRQ_EN = 8'h54;
   localparam int UID_SEL_BIT = 7;
   // Operating modes and commands
   localparam logic [2:0] MODE_READ = 3'h0;
   localparam logic [2:0] MODE_DATA_PE = 3'h2;
   localparam logic [2:0] MODE_DISCH1 = 3'h3;
   localparam logic [2:0] MODE_CODE_PE = 3'h5;
   localparam logic [2:0] MODE_DISCH2 = 3'h7;
   localparam logic [3:0] CMD_PROGRAM = 4'h1;
   localparam logic [3:0] CMD_BLANK = 4'h3;
   localparam logic [3:0] CMD_ERASE = 4'h4;
   localparam logic [3:0] CMD_UID = 4'h5;
   // Command register control bits
   localparam int CMD_ACK_BIT = 4;
   localparam int CMD_STOP_BIT = 5;
   // Interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_RDY = 2;
   // Array geometry and reset values
   localparam logic [7:0] DATA_AREA_TAG = 8'h00;
   localparam logic [3:0] CODE_FLOOR_128K = 4'hE;
   localparam logic [9:0] STARTUP_LAST_BLOCK = 10'h00F;
   localparam logic [9:0] WINDOW_BLANK = 10'h3FF;
   localparam logic [19:0] WINDOW_INFO_ADDR = 20'h00010;
   localparam logic [19:0] STARTUP_INFO_ADDR = 20'h00000;
   localparam logic [19:0] CODE_STEP = 20'h00004;
   localparam logic [19:0] DATA_STEP = 20'h00001;
   localparam logic [19:0] BLOCK_STEP = 20'h00400;
   localparam logic [2:0] UID_LAST_WORD = 3'h7;
   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT_ACK} seq_state_e;
endpackage : flash_seq_pkg

// File: logic/flash_pe_command_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Done or forced stop raises done interrupt
// - Mode field gates which area may run
// - Area bit picks user/data or extra area
// - Only program, blank, erase, ID commands accepted
// - Start address in high and low registers
// - End address in high and low registers
// - Error monitor keeps failing address bits 19:16
// - Program data from write buffer pair
// - Window start monitor blank ones, then buffer
// - Window end monitor blank ones, then buffer
// - Unique ID as 32 readable bytes
// - Start-up protection guards code blocks 0-15
// - Area window rejects programming outside it
// - Code stays readable during data operations
// - Code area floor by size; data area
module flash_pe_command_sequencer
   import flash_seq_pkg::*;
#(
   parameter logic [3:0] CODE_FLOOR = CODE_FLOOR_128K
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic flash_req_out,
   output logic [3:0] flash_cmd_out,
   output logic [19:0] flash_addr_out,
   output logic flash_extra_out,
   output logic [31:0] flash_wdata_out,
   input wire logic flash_ack_in,
   input wire logic flash_err_in,
   input wire logic [31:0] flash_rdata_in,
   output logic code_read_ok_out,
   output logic sequencer_done_irq_out
);

   typedef struct packed {
      seq_state_e state;
      logic [2:0] mode;
      logic extra;
      logic [3:0] cmd;
      logic tgt_data;
      logic data_entry;
      logic data_ctrl;
      logic protect;
      logic [7:0] sah;
      logic [15:0] sal;
      logic [7:0] eah;
      logic [15:0] eal;
      logic [15:0] wbh;
      logic [15:0] wbl;
      logic [15:0] rbh;
      logic [15:0] rbl;
      logic rdy_flag;
      logic err;
      logic [7:0] eam;
      logic [9:0] wsm;
      logic [9:0] wem;
      logic [7:0] scm;
      logic [2:0] ist;
      logic [2:0] ien;
      logic [19:0] cur;
      logic [2:0] uidx;
      logic [31:0][7:0] uid;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic freq;
      logic code_ok;
      logic irq;
   } state_s;

   state_s s, n;
   logic acc, wr, to_data, cmd_ok, mode_ok, start, last, hit;
   logic [19:0] st_addr, end_addr, step;
   logic [2:0] ev;
   logic [31:0] rd;

   // Code block number counts down from the top of the array
   function automatic logic prot_bad(input logic [19:0] a, input logic [3:0] c,
                                     input logic ex, input logic pr,
                                     input logic [9:0] ws, input logic [9:0] we);
      logic [9:0] blk;
      logic code;
      blk = {3'h0, ~a[16:10]};
      code = !ex && a[19:12] != DATA_AREA_TAG;
      prot_bad = 1'b0;
      if (code && (c == CMD_PROGRAM || c == CMD_ERASE || c == CMD_BLANK)) begin
         prot_bad = a[19:16] < CODE_FLOOR;
      end
      if (code && (c == CMD_PROGRAM || c == CMD_ERASE)) begin
         if (pr && blk <= STARTUP_LAST_BLOCK) begin
            prot_bad = 1'b1;
         end
         if (ws != we && (blk < ws || blk >= we)) begin
            prot_bad = 1'b1;
         end
      end
   endfunction : prot_bad

   // Bus qualifiers and command decode
   assign acc = psel_in && penable_in && s.pready;
   assign wr = acc && pwrite_in;
   assign st_addr = {s.sah[3:0], s.sal};
   assign end_addr = {s.eah[3:0], s.eal};
   assign to_data = !s.extra && st_addr[19:12] == DATA_AREA_TAG;
   assign cmd_ok = pwdata_in[3:0] == CMD_PROGRAM || pwdata_in[3:0] == CMD_BLANK
                   || pwdata_in[3:0] == CMD_ERASE || pwdata_in[3:0] == CMD_UID;
   assign start = wr && paddr_in == OFS_CMD && pwdata_in[3:0] != 4'h0
                  && s.state == ST_IDLE;
   assign last = s.cur >= end_addr;

   // Area and mode legality at command start
   always_comb begin
      if (pwdata_in[3:0] == CMD_UID) begin
         mode_ok = s.mode == MODE_CODE_PE || s.mode == MODE_DATA_PE;
      end else if (to_data) begin
         mode_ok = s.mode == MODE_DATA_PE && s.data_entry && s.data_ctrl;
      end else begin
         mode_ok = s.mode == MODE_CODE_PE;
      end
   end

   // Address step per command and area
   always_comb begin
      if (s.cmd == CMD_ERASE) begin
         step = BLOCK_STEP;
      end else if (s.tgt_data) begin
         step = DATA_STEP;
      end else begin
         step = CODE_STEP;
      end
   end

   // Register read multiplexer
   always_comb begin
      rd = 32'h0000_0000;
      hit = 1'b1;
      if (paddr_in[UID_SEL_BIT]) begin
         rd = {24'h00_0000, s.uid[paddr_in[6:2]]};
      end else begin
         case (paddr_in)
            OFS_MODE: rd = {29'h0, s.mode};
            OFS_AREA: rd = {31'h0, s.extra};
            OFS_CMD: rd = {28'h0, s.cmd};
            OFS_ENTRY: rd = {31'h0, s.data_entry};
            OFS_DATA_CTRL: rd = {31'h0, s.data_ctrl};
            OFS_SAH: rd = {24'h0, s.sah};
            OFS_SAL: rd = {16'h0, s.sal};
            OFS_EAH: rd = {24'h0, s.eah};
            OFS_EAL: rd = {16'h0, s.eal};
            OFS_WBH: rd = {16'h0, s.wbh};
            OFS_WBL: rd = {16'h0, s.wbl};
            OFS_RBH: rd = {16'h0, s.rbh};
            OFS_RBL: rd = {16'h0, s.rbl};
            OFS_STAT1: rd = {29'h0, s.err, s.state != ST_IDLE, s.rdy_flag};
            OFS_EAM: rd = {24'h0, s.eam};
            OFS_WSM: rd = {22'h0, s.wsm};
            OFS_WEM: rd = {22'h0, s.wem};
            OFS_SCM: rd = {24'h0, s.scm};
            OFS_PROT: rd = {31'h0, s.protect};
            OFS_IRQ_STAT: rd = {29'h0, s.ist};
            OFS_IRQ_CLR: rd = 32'h0000_0000;
            OFS_IRQ_EN: rd = {29'h0, s.ien};
            default: hit = 1'b0;
         endcase
      end
   end

   // Next state: bus slave, registers, sequencer
   always_comb begin
      n = s;
      ev = 3'h0;
      n.pready = psel_in && penable_in && !s.pready;
      n.pslverr = 1'b0;
      if (psel_in && penable_in && !s.pready) begin
         n.prdata = rd;
         n.pslverr = !hit || (pwrite_in && paddr_in[UID_SEL_BIT]);
      end
      if (wr) begin
         case (paddr_in)
            OFS_MODE: n.mode = pwdata_in[2:0];
            OFS_AREA: n.extra = pwdata_in[0];
            OFS_ENTRY: n.data_entry = pwdata_in[0];
            OFS_DATA_CTRL: n.data_ctrl = pwdata_in[0];
            OFS_SAH: n.sah = pwdata_in[7:0];
            OFS_SAL: n.sal = pwdata_in[15:0];
            OFS_EAH: n.eah = pwdata_in[7:0];
            OFS_EAL: n.eal = pwdata_in[15:0];
            OFS_WBH: n.wbh = pwdata_in[15:0];
            OFS_WBL: n.wbl = pwdata_in[15:0];
            OFS_PROT: n.protect = pwdata_in[0];
            OFS_IRQ_EN: n.ien = pwdata_in[2:0];
            default: n.mode = n.mode;
         endcase
      end
      // Forced stop ends any command and reports completion
      if (wr && paddr_in == OFS_CMD && pwdata_in[CMD_STOP_BIT]) begin
         n.state = ST_IDLE;
         n.rdy_flag = 1'b0;
         ev[IRQ_DONE] = 1'b1;
      end else begin
         case (s.state)
            ST_IDLE: begin
               if (start) begin
                  n.cmd = pwdata_in[3:0];
                  n.err = 1'b0;
                  n.tgt_data = to_data;
                  n.cur = st_addr;
                  n.uidx = 3'h0;
                  if (pwdata_in[3:0] == CMD_UID) begin
                     n.cur = 20'h00000;
                  end
                  if (cmd_ok && mode_ok) begin
                     n.state = ST_REQ;
                  end else begin
                     n.err = 1'b1;
                     ev[IRQ_ERR] = 1'b1;
                     ev[IRQ_DONE] = 1'b1;
                  end
               end
            end
            ST_REQ: begin
               if (!s.freq || (flash_ack_in && flash_err_in)) begin
                  // Protected address never reaches the array; failure ends run
                  n.err = 1'b1;
                  n.eam = {4'h0, s.cur[19:16]};
                  n.state = ST_IDLE;
                  ev[IRQ_ERR] = 1'b1;
                  ev[IRQ_DONE] = 1'b1;
               end else if (flash_ack_in && s.cmd == CMD_UID) begin
                  n.rbh = flash_rdata_in[31:16];
                  n.rbl = flash_rdata_in[15:0];
                  n.uid[{s.uidx, 2'h0}] = flash_rdata_in[7:0];
                  n.uid[{s.uidx, 2'h1}] = flash_rdata_in[15:8];
                  n.uid[{s.uidx, 2'h2}] = flash_rdata_in[23:16];
                  n.uid[{s.uidx, 2'h3}] = flash_rdata_in[31:24];
                  n.rdy_flag = 1'b1;
                  ev[IRQ_RDY] = 1'b1;
                  n.state = ST_WAIT_ACK;
               end else if (flash_ack_in) begin
                  if (s.cmd == CMD_PROGRAM && s.extra && s.cur == WINDOW_INFO_ADDR) begin
                     n.wsm = s.wbl[9:0];
                     n.wem = s.wbh[9:0];
                  end
                  if (s.cmd == CMD_PROGRAM && s.extra && s.cur == STARTUP_INFO_ADDR) begin
                     n.scm = s.wbl[7:0];
                  end
                  if (last) begin
                     n.state = ST_IDLE;
                     ev[IRQ_DONE] = 1'b1;
                  end else begin
                     n.cur = s.cur + step;
                  end
               end
            end
            ST_WAIT_ACK: begin
               if (wr && paddr_in == OFS_CMD && pwdata_in[CMD_ACK_BIT]) begin
                  n.rdy_flag = 1'b0;
                  if (s.uidx == UID_LAST_WORD) begin
                     n.state = ST_IDLE;
                     ev[IRQ_DONE] = 1'b1;
                  end else begin
                     n.uidx = s.uidx + 3'h1;
                     n.cur = s.cur + CODE_STEP;
                     n.state = ST_REQ;
                  end
               end
            end
            default: n.state = ST_IDLE;
         endcase
      end
      // Sticky status: a new event wins over a clear in the same cycle
      if (wr && paddr_in == OFS_IRQ_CLR) begin
         n.ist = s.ist & ~pwdata_in[2:0];
      end
      n.ist = n.ist | ev;
      n.irq = |(n.ist & n.ien);
      n.freq = n.state == ST_REQ
               && !prot_bad(n.cur, n.cmd, n.extra, n.protect, n.wsm, n.wem);
      n.code_ok = n.state == ST_IDLE || n.tgt_data || n.cmd == CMD_UID;
   end

   // State register with synchronous reset
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         s <= '0;
         s.wsm <= WINDOW_BLANK;
         s.wem <= WINDOW_BLANK;
         s.code_ok <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // Outputs straight from the state register
   assign prdata_out = s.prdata;
   assign pready_out = s.pready;
   assign pslverr_out = s.pslverr;
   assign flash_req_out = s.freq;
   assign flash_cmd_out = s.cmd;
   assign flash_addr_out = s.cur;
   assign flash_extra_out = s.extra;
   assign flash_wdata_out = {s.wbh, s.wbl};
   assign code_read_ok_out = s.code_ok;
   assign sequencer_done_irq_out = s.irq;

   // Checks on the sequencer's own behaviour
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   AST_DONE_IRQ: assert property (
      (s.state == ST_REQ && s.freq && flash_ack_in && !flash_err_in && last
       && s.cmd != CMD_UID && !wr) |=> (s.state == ST_IDLE && s.ist[IRQ_DONE]))
      else $error("command end did not set done status");
   AST_IRQ_LEVEL: assert property (
      (|(s.ist & s.ien)) |-> ##[0:1] sequencer_done_irq_out)
      else $error("enabled status without interrupt");
   AST_MODE_GUARD: assert property (
      (start && !mode_ok) |=> (s.state == ST_IDLE && s.err && !flash_req_out))
      else $error("command ran in wrong mode");
   AST_CMD_GUARD: assert property (
      (start && !cmd_ok) |=> (s.err && s.state == ST_IDLE))
      else $error("illegal command not refused");
   AST_ERR_ADDR: assert property (
      (s.state == ST_REQ && s.freq && flash_ack_in && flash_err_in)
      |=> (s.eam[3:0] == $past(s.cur[19:16]) && s.ist[IRQ_ERR]))
      else $error("error address not captured");
   AST_WIN_START: assert property (
      (s.state == ST_REQ && s.freq && flash_ack_in && !flash_err_in
       && s.cmd == CMD_PROGRAM && s.extra && s.cur == WINDOW_INFO_ADDR)
      |=> s.wsm == $past(s.wbl[9:0]))
      else $error("window start monitor not updated");
   AST_WIN_END: assert property (
      (s.state == ST_REQ && s.freq && flash_ack_in && !flash_err_in
       && s.cmd == CMD_PROGRAM && s.extra && s.cur == WINDOW_INFO_ADDR)
      |=> s.wem == $past(s.wbh[9:0]))
      else $error("window end monitor not updated");
   AST_STARTUP_PROT: assert property (
      (flash_req_out && s.protect && !s.extra && !s.tgt_data
       && (s.cmd == CMD_PROGRAM || s.cmd == CMD_ERASE))
      |-> ({3'h0, ~flash_addr_out[16:10]} > STARTUP_LAST_BLOCK))
      else $error("protected start-up block reached array");
   AST_BGO: assert property (
      (s.state != ST_IDLE && s.tgt_data) |-> code_read_ok_out)
      else $error("code reads blocked during data operation");
   AST_ID_READY: assert property (
      (s.state == ST_REQ && s.freq && flash_ack_in && !flash_err_in
       && s.cmd == CMD_UID && !wr)
      |=> (s.rdy_flag && !flash_req_out) ##1 (s.rdy_flag || s.state != ST_WAIT_ACK))
      else $error("read ready flag not raised");

   COV_PROGRAM_DONE: cover property (
      s.state == ST_REQ && s.cmd == CMD_PROGRAM ##1 s.state == ST_IDLE && !s.err);
   COV_UID_LAST: cover property (
      s.state == ST_WAIT_ACK && s.uidx == UID_LAST_WORD ##1 s.state == ST_IDLE);
   COV_FORCED_STOP: cover property (
      s.state == ST_REQ && wr && paddr_in == OFS_CMD && pwdata_in[CMD_STOP_BIT]);

endmodule : flash_pe_command_sequencer
`default_nettype wire

// File: tb/flash_array_model.sv
`timescale 1ns/1ps
`default_nettype none
// Flash array stand-in: one access at a time, stall set by delay_in
module flash_array_model
   import flash_seq_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic req_in,
   input wire logic [3:0] cmd_in,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] delay_in,
   input wire logic fail_in,
   output logic ack_out,
   output logic err_out,
   output logic [31:0] rdata_out,
   output var int acks_out,
   output logic [31:0] last_wdata_out
);
   logic [3:0] stall;
   logic [2:0] word;
   logic [7:0] base;
   // Lowest id byte of the next word
   assign base = 8'hC0 + {3'h0, word, 2'h0};
   // Answer after the stall; unqualified lines keep changing
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ack_out <= 1'b0;
         err_out <= 1'b0;
         rdata_out <= 32'h0;
         acks_out <= 0;
         last_wdata_out <= 32'h0;
         stall <= 4'h0;
         word <= 3'h0;
      end else if (req_in && !ack_out && stall >= delay_in) begin
         ack_out <= 1'b1;
         err_out <= fail_in;
         acks_out <= acks_out + 1;
         last_wdata_out <= wdata_in;
         stall <= 4'h0;
         if (cmd_in == CMD_UID) begin
            rdata_out <= {base + 8'h3, base + 8'h2, base + 8'h1, base};
            word <= word + 3'h1;
         end
      end else begin
         ack_out <= 1'b0;
         err_out <= ~err_out;
         rdata_out <= ~rdata_out;
         stall <= req_in ? stall + 4'h1 : 4'h0;
      end
   end
endmodule : flash_array_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import flash_seq_pkg::*;
   typedef struct {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0] err;
   } row_s;
   logic clk_in, reset_n_in, psel, penable, pwrite, pready, pslverr, er, werr;
   logic req, extra, code_ok, irq, ack, ferr, fail, ack_extra;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, fwdata, frdata, last_wdata;
   logic [3:0] fcmd, dly;
   logic [19:0] faddr, ack_addr;
   int acks, miscompares, checks, code_low, a0, c0;
   row_s rows[18];

   flash_pe_command_sequencer #(.CODE_FLOOR(CODE_FLOOR_128K)) u_dut (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .flash_req_out(req), .flash_cmd_out(fcmd),
      .flash_addr_out(faddr), .flash_extra_out(extra), .flash_wdata_out(fwdata),
      .flash_ack_in(ack), .flash_err_in(ferr), .flash_rdata_in(frdata),
      .code_read_ok_out(code_ok), .sequencer_done_irq_out(irq));
   flash_array_model u_array (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req), .cmd_in(fcmd),
      .wdata_in(fwdata), .delay_in(dly), .fail_in(fail), .ack_out(ack), .err_out(ferr),
      .rdata_out(frdata), .acks_out(acks), .last_wdata_out(last_wdata));

   // Free-running 100 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Count blocked fetch cycles, note address and area at each answer
   always @(posedge clk_in) begin
      if (code_ok === 1'b0) code_low <= code_low + 1;
      if (ack === 1'b1) begin
         ack_addr <= faddr;
         ack_extra <= extra;
      end
   end

   task automatic give_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   task automatic hang(input string what);
      miscompares++;
      $display("mismatch %s expected answer seen none", what);
      give_verdict();
   endtask : hang

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) hang("apb ready");
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(what, e, rd);
   endtask : rdchk

   task automatic wait_irq();
      int n;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (irq !== 1'b1 && n < 300);
      if (n >= 300) hang("interrupt");
   endtask : wait_irq

   // Issue a command, check status and access count, then clear
   task automatic op(input logic [31:0] c, input logic [31:0] st, input int n);
      a0 = acks;
      wr(OFS_CMD, c);
      wait_irq();
      rdchk("irq status", OFS_IRQ_STAT, st);
      chk("array accesses", 32'(n), 32'(acks - a0));
      wr(OFS_IRQ_CLR, 32'h7);
      repeat (2) @(negedge clk_in);
      chk("irq line after clear", 32'h0, 32'(irq));
   endtask : op

   task automatic span(input logic [19:0] s, input logic [19:0] e);
      wr(OFS_SAH, 32'(s[19:16]));
      wr(OFS_SAL, 32'(s[15:0]));
      wr(OFS_EAH, 32'(e[19:16]));
      wr(OFS_EAL, 32'(e[15:0]));
   endtask : span

   function automatic logic [31:0] uidw(input int w);
      logic [7:0] b;
      b = 8'(8'hC0 + 4 * w);
      return {b + 8'h3, b + 8'h2, b + 8'h1, b};
   endfunction : uidw

   // Main sequence
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      reset_n_in = 1'b0;
      fail = 1'b0;
      dly = 4'h0;
      rows[0] = '{OFS_SAH, 32'h5, 32'h5, 2'b00};
      rows[1] = '{OFS_SAL, 32'h1234, 32'h1234, 2'b00};
      rows[2] = '{OFS_EAH, 32'h5, 32'h5, 2'b00};
      rows[3] = '{OFS_EAL, 32'h1238, 32'h1238, 2'b00};
      rows[4] = '{OFS_MODE, 32'(MODE_DATA_PE), 32'(MODE_DATA_PE), 2'b00};
      rows[5] = '{OFS_MODE, 32'(MODE_DISCH1), 32'(MODE_DISCH1), 2'b00};
      rows[6] = '{OFS_MODE, 32'(MODE_CODE_PE), 32'(MODE_CODE_PE), 2'b00};
      rows[7] = '{OFS_MODE, 32'(MODE_DISCH2), 32'(MODE_DISCH2), 2'b00};
      rows[8] = '{OFS_MODE, 32'(MODE_READ), 32'(MODE_READ), 2'b00};
      rows[9] = '{OFS_AREA, 32'h1, 32'h1, 2'b00};
      rows[10] = '{OFS_AREA, 32'h0, 32'h0, 2'b00};
      rows[11] = '{OFS_WBH, 32'hBEEF, 32'hBEEF, 2'b00};
      rows[12] = '{OFS_WBL, 32'hCAFE, 32'hCAFE, 2'b00};
      rows[13] = '{OFS_EAM, 32'hF, 32'h0, 2'b00};
      rows[14] = '{8'h60, 32'h5, 32'h0, 2'b11};
      rows[15] = '{8'h80, 32'h5, 32'h0, 2'b10};
      rows[16] = '{OFS_WSM, 32'h0, 32'h3FF, 2'b00};
      rows[17] = '{OFS_WEM, 32'h0, 32'h3FF, 2'b00};
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(negedge clk_in);
      chk("irq after reset", 32'h0, 32'(irq));
      chk("code fetch after reset", 32'h1, 32'(code_ok));
      $display("test reset finished");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         werr = er;
         apb(1'b0, rows[i].a, 32'h0);
         chk("register value", rows[i].e, rd);
         chk("error response", 32'(rows[i].err), 32'({werr, er}));
      end
      $display("test registers finished");
      // Data area program, slow array, code stays readable
      dly <= 4'h3;
      wr(OFS_IRQ_EN, 32'h7);
      wr(OFS_MODE, 32'(MODE_DATA_PE));
      wr(OFS_ENTRY, 32'h1);
      wr(OFS_DATA_CTRL, 32'h1);
      span(20'h00010, 20'h00011);
      c0 = code_low;
      op(32'(CMD_PROGRAM), 32'h1, 2);
      chk("program data", 32'hBEEFCAFE, last_wdata);
      chk("acked address", 32'h00011, 32'(ack_addr));
      chk("acked area select", 32'h0, 32'(ack_extra));
      chk("code fetch blocked cycles", 32'h0, 32'(code_low - c0));
      $display("test data program finished");
      // Code area blank check failure and erase at the floor
      dly <= 4'h0;
      wr(OFS_MODE, 32'(MODE_CODE_PE));
      span(20'hE0000, 20'hE0000);
      fail <= 1'b1;
      c0 = code_low;
      op(32'(CMD_BLANK), 32'h3, 1);
      fail <= 1'b0;
      rdchk("error address", OFS_EAM, 32'hE);
      chk("code fetch blocked", 32'h1, 32'(code_low > c0));
      op(32'(CMD_ERASE), 32'h1, 1);
      $display("test code blank and erase finished");
      // Start-up protection refuses block 0
      wr(OFS_PROT, 32'h1);
      span(20'hFFC00, 20'hFFC00);
      op(32'(CMD_PROGRAM), 32'h3, 0);
      rdchk("error address", OFS_EAM, 32'hF);
      wr(OFS_PROT, 32'h0);
      $display("test start-up protection finished");
      // Access window program, then programming inside and outside it
      wr(OFS_AREA, 32'h1);
      span(20'h00010, 20'h00010);
      wr(OFS_WBL, 32'h2);
      wr(OFS_WBH, 32'h4);
      op(32'(CMD_PROGRAM), 32'h1, 1);
      rdchk("window start", OFS_WSM, 32'h2);
      rdchk("window end", OFS_WEM, 32'h4);
      chk("acked area select", 32'h1, 32'(ack_extra));
      wr(OFS_AREA, 32'h0);
      span(20'hFFC00, 20'hFFC00);
      op(32'(CMD_PROGRAM), 32'h3, 0);
      span(20'hFF400, 20'hFF400);
      op(32'(CMD_PROGRAM), 32'h1, 1);
      chk("acked address", 32'hFF400, 32'(ack_addr));
      $display("test access window finished");
      // Illegal command, illegal mode, forced stop while idle
      op(32'h2, 32'h3, 0);
      wr(OFS_MODE, 32'h1);
      op(32'(CMD_PROGRAM), 32'h3, 0);
      wr(OFS_MODE, 32'(MODE_CODE_PE));
      op(32'(1 << CMD_STOP_BIT), 32'h1, 0);
      // Forced stop while a slow program is still waiting on the array
      dly <= 4'hF;
      a0 = acks;
      wr(OFS_CMD, 32'(CMD_PROGRAM));
      wr(OFS_CMD, 32'(1 << CMD_STOP_BIT));
      wait_irq();
      rdchk("irq status after stop", OFS_IRQ_STAT, 32'h1);
      chk("array accesses after stop", 32'h0, 32'(acks - a0));
      wr(OFS_IRQ_CLR, 32'h7);
      $display("test refusals and stop finished");
      // Unique id read, word by word through the read buffers
      dly <= 4'h2;
      a0 = acks;
      wr(OFS_CMD, 32'(CMD_UID));
      for (int w = 0; w < 8; w++) begin
         wait_irq();
         apb(1'b0, OFS_STAT1, 32'h0);
         chk("read ready", 32'h1, 32'(rd[0]));
         rdchk("read buffer low", OFS_RBL, uidw(w) & 32'hFFFF);
         rdchk("read buffer high", OFS_RBH, uidw(w) >> 16);
         wr(OFS_IRQ_CLR, 32'(1 << IRQ_RDY));
         wr(OFS_CMD, 32'(1 << CMD_ACK_BIT));
      end
      wait_irq();
      rdchk("irq status", OFS_IRQ_STAT, 32'h1);
      chk("id words", 32'h8, 32'(acks - a0));
      wr(OFS_IRQ_CLR, 32'h7);
      for (int i = 0; i < 32; i++) begin
         rdchk("id byte", 8'(8'h80 + 4 * i), 32'(8'hC0 + i));
      end
      $display("test unique id finished");
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
